// [verilog/cfam_pkg.sv]
// Package: constants and carriers for the flag logic and address decoder
package cfam_pkg;

  // ********************
  // Register offsets (byte addresses)
  // ********************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_ACC = 8'h0C;
  localparam logic [7:0] OFS_INDEX_BYTE = 8'h10;
  localparam logic [7:0] OFS_DECODE = 8'h14;

  // ********************
  // Field positions and reset values
  // ********************
  localparam int CTRL_RAM_LSB = 0;
  localparam int CTRL_ROM_LSB = 2;
  localparam int CTRL_VEC_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int ST_DEC_BIT = 3;
  localparam int ST_MM_BIT = 5;
  localparam int ST_OVF_BIT = 6;
  localparam int ST_SIGN_BIT = 7;
  localparam int CMD_OPND_LSB = 8;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ********************
  // Command codes
  // ********************
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_MEMMODE_ON = 4'h1;
  localparam logic [3:0] OP_MEMMODE_OFF = 4'h2;
  localparam logic [3:0] OP_OVF_CLEAR = 4'h3;
  localparam logic [3:0] OP_DEC_ON = 4'h4;
  localparam logic [3:0] OP_DEC_OFF = 4'h5;
  localparam logic [3:0] OP_BIT_TEST = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_LOAD = 4'h9;

  // ********************
  // Address map
  // ********************
  localparam logic [15:0] RAM_END_128 = 16'h007F;
  localparam logic [15:0] RAM_END_192 = 16'h00BF;
  localparam logic [15:0] RAM_HI_BASE = 16'h0100;
  localparam logic [15:0] RAM_HI_END = 16'h01BF;
  localparam logic [15:0] PERIPH_REG_AREA_BASE = 16'h00C0;
  localparam logic [15:0] PERIPH_REG_AREA_END = 16'h00FF;
  localparam logic [15:0] ROM_BASE_4K = 16'hF000;
  localparam logic [15:0] ROM_BASE_8K = 16'hE000;
  localparam logic [15:0] ROM_BASE_16K = 16'hC000;
  localparam logic [15:0] VEC_BASE_SMALL = 16'hFFEA;
  localparam logic [15:0] VEC_BASE_LARGE = 16'hFFE8;
  localparam logic [7:0] ZERO_PAGE_HI = 8'h00;
  localparam logic [7:0] SPECIAL_PAGE_HI = 8'hFF;

  localparam logic [3:0] RGN_NONE = 4'h0;
  localparam logic [3:0] RGN_RAM = 4'h1;
  localparam logic [3:0] RGN_PERIPH_REG_AREA = 4'h2;
  localparam logic [3:0] RGN_ROM = 4'h3;
  localparam logic [3:0] RGN_VEC = 4'h4;

  // Addressing modes and their cost
  localparam logic [1:0] MODE_ABS = 2'h0;
  localparam logic [1:0] MODE_ZP = 2'h1;
  localparam logic [1:0] MODE_SP_CALL = 2'h2;
  localparam logic [1:0] MODE_ABS_CALL = 2'h3;
  localparam logic [3:0] BYTES_SHORT = 4'h2;
  localparam logic [3:0] BYTES_LONG = 4'h3;
  localparam logic [3:0] CYC_ZP = 4'h3;
  localparam logic [3:0] CYC_ABS = 4'h4;
  localparam logic [3:0] CYC_SP_CALL = 4'h5;
  localparam logic [3:0] CYC_ABS_CALL = 4'h6;

  typedef struct packed {
    logic [3:0] cycles;
    logic [3:0] bytes;
    logic [3:0] region;
    logic [1:0] pad;
    logic [1:0] mode;
    logic [15:0] addr;
  } cfam_dec_t;

  typedef struct packed {
    logic sign;
    logic ovf;
    logic memmode;
    logic dec;
  } cfam_flags_t;

endpackage

// [verilog/cfam_top.sv]
// Processor flag logic and address-space decoder behind a Wishbone slave
//
// Summary of operation
// - Memory mode: result written to index byte
// - Normal mode: result written to accumulator
// - Commands set and clear memory mode flag
// - Overflow set on signed range overflow
// - Bit test copies bit 6 to overflow
// - Overflow only cleared, never set directly
// - Sign follows bit 7 of result
// - Bit test copies bit 7 to sign
// - One flat 64K space for everything
// - Low 256 bytes form zero page
// - Zero page costs fewer cycles than absolute
// - Top page allows shorter subroutine jump
// - C0 to FF routed to peripheral area
// - Vector table at top, per variant
// - RAM range chosen by RAM size
// - ROM base chosen by ROM size
// - Zero page modes reach zero page only
// - Memory mode flag lives at bit 5
// - Bit 3 selects decimal add and subtract
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module cfam_top
  import cfam_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic RAM_SEL,
  output logic PERIPH_REG_AREA_SEL,
  output logic ROM_SEL,
  output logic VEC_SEL
);

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // Add or subtract, with per-digit correction in decimal mode
  function automatic logic [7:0] alu(input logic [7:0] a, input logic [7:0] b,
                                     input logic sub, input logic dec);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = 5'h00;
    hi = 5'h00;
    if (!dec)
      return sub ? 8'(a - b) : 8'(a + b);
    if (!sub)
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      if (lo > 5'h09)
        lo = 5'(lo + 5'h06);
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      if (hi > 5'h09)
        hi = 5'(hi + 5'h06);
    end
    else
    begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      if (lo[4])
        lo = 5'(lo - 5'h06);
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
      if (hi[4])
        hi = 5'(hi - 5'h06);
    end
    return {hi[3:0], lo[3:0]};
  endfunction

  // Region, cost and effective address of one access
  function automatic cfam_dec_t decode(input logic [15:0] a, input logic [1:0] mode,
                                       input logic [4:0] ctrl);
    cfam_dec_t d;
    logic [15:0] rom_base;
    logic [15:0] ram_end;
    d = '0;
    d.mode = mode;
    case (mode)
      MODE_ZP:
      begin
        d.addr = {ZERO_PAGE_HI, a[7:0]};
        d.bytes = BYTES_SHORT;
        d.cycles = CYC_ZP;
      end
      MODE_SP_CALL:
      begin
        d.addr = {SPECIAL_PAGE_HI, a[7:0]};
        d.bytes = BYTES_SHORT;
        d.cycles = CYC_SP_CALL;
      end
      MODE_ABS_CALL:
      begin
        d.addr = a;
        d.bytes = BYTES_LONG;
        d.cycles = CYC_ABS_CALL;
      end
      default:
      begin
        d.addr = a;
        d.bytes = BYTES_LONG;
        d.cycles = CYC_ABS;
      end
    endcase
    case (ctrl[CTRL_ROM_LSB +: 2])
      2'h1: rom_base = ROM_BASE_8K;
      2'h2: rom_base = ROM_BASE_16K;
      default: rom_base = ROM_BASE_4K;
    endcase
    ram_end = (ctrl[CTRL_RAM_LSB +: 2] == 2'h0) ? RAM_END_128 : RAM_END_192;
    if (d.addr >= (ctrl[CTRL_VEC_BIT] ? VEC_BASE_LARGE : VEC_BASE_SMALL))
      d.region = RGN_VEC;
    else if (d.addr >= rom_base)
      d.region = RGN_ROM;
    else if (d.addr >= PERIPH_REG_AREA_BASE && d.addr <= PERIPH_REG_AREA_END)
      d.region = RGN_PERIPH_REG_AREA;
    else if (d.addr <= ram_end)
      d.region = RGN_RAM;
    else if (ctrl[CTRL_RAM_LSB +: 2] == 2'h2 && d.addr >= RAM_HI_BASE && d.addr <= RAM_HI_END)
      d.region = RGN_RAM;
    else
      d.region = RGN_NONE;
    return d;
  endfunction

  // ********************
  // Bus slave
  // ********************
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [4:0] ctrl_ff;
  cfam_flags_t flags_ff;
  logic [7:0] acc_ff;
  logic [7:0] idx_byte_ff;
  cfam_dec_t dec_ff;
  logic req;
  logic wr;
  logic cmd_exec;
  logic [3:0] op;
  logic [7:0] opnd;
  logic [31:0] nxt_rdata;
  logic [7:0] status;
  logic [7:0] alu_a;
  logic [7:0] alu_r;
  logic alu_ovf;

  assign req = WB_CYC_I & WB_STB_I;
  // Writes land on the edge where ack is seen high
  assign wr = req & WB_WE_I & ack_ff;
  assign cmd_exec = wr && WB_ADR_I == OFS_CMD;
  assign op = WB_DAT_I[3:0];
  assign opnd = WB_DAT_I[CMD_OPND_LSB +: 8];
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;

  always_comb
  begin
    status = 8'h00;
    status[ST_SIGN_BIT] = flags_ff.sign;
    status[ST_OVF_BIT] = flags_ff.ovf;
    status[ST_MM_BIT] = flags_ff.memmode;
    status[ST_DEC_BIT] = flags_ff.dec;
  end

  always_comb
  begin
    case (WB_ADR_I)
      OFS_CTRL: nxt_rdata = {27'h0, ctrl_ff};
      OFS_STATUS: nxt_rdata = {24'h0, status};
      OFS_ACC: nxt_rdata = {24'h0, acc_ff};
      OFS_INDEX_BYTE: nxt_rdata = {24'h0, idx_byte_ff};
      OFS_DECODE: nxt_rdata = dec_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      rdata_ff <= 32'h0000_0000;
    else if (req & ~ack_ff)
      rdata_ff <= nxt_rdata;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      ctrl_ff <= CTRL_RST;
    else if (wr && WB_ADR_I == OFS_CTRL)
      ctrl_ff <= 5'(lane_merge({27'h0, ctrl_ff}, WB_DAT_I, WB_SEL_I));
  end

  // ********************
  // Flags and arithmetic
  // ********************
  assign alu_a = flags_ff.memmode ? idx_byte_ff : acc_ff;
  assign alu_r = alu(alu_a, opnd, op == OP_SUB, flags_ff.dec);
  assign alu_ovf = (op == OP_SUB) ? (alu_a[7] != opnd[7]) && (alu_r[7] != alu_a[7])
                                  : (alu_a[7] == opnd[7]) && (alu_r[7] != alu_a[7]);

  // Undefined after reset; forced to a known value anyway
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      flags_ff <= '0;
    else if (cmd_exec)
    begin
      case (op)
        OP_MEMMODE_ON: flags_ff.memmode <= 1'b1;
        OP_MEMMODE_OFF: flags_ff.memmode <= 1'b0;
        OP_OVF_CLEAR: flags_ff.ovf <= 1'b0;
        OP_DEC_ON: flags_ff.dec <= 1'b1;
        OP_DEC_OFF: flags_ff.dec <= 1'b0;
        OP_BIT_TEST:
        begin
          flags_ff.ovf <= opnd[6];
          flags_ff.sign <= opnd[7];
        end
        OP_ADD, OP_SUB:
        begin
          // In decimal mode both flags are meaningless but still updated
          flags_ff.ovf <= alu_ovf;
          flags_ff.sign <= alu_r[7];
        end
        OP_LOAD: flags_ff.sign <= opnd[7];
        default: flags_ff <= flags_ff;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      acc_ff <= BYTE_RST;
    else if (cmd_exec && !flags_ff.memmode && (op == OP_ADD || op == OP_SUB))
      acc_ff <= alu_r;
    else if (cmd_exec && !flags_ff.memmode && op == OP_LOAD)
      acc_ff <= opnd;
    else if (wr && WB_ADR_I == OFS_ACC && WB_SEL_I[0])
      acc_ff <= WB_DAT_I[7:0];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      idx_byte_ff <= BYTE_RST;
    else if (cmd_exec && flags_ff.memmode && (op == OP_ADD || op == OP_SUB))
      idx_byte_ff <= alu_r;
    else if (cmd_exec && flags_ff.memmode && op == OP_LOAD)
      idx_byte_ff <= opnd;
    else if (wr && WB_ADR_I == OFS_INDEX_BYTE && WB_SEL_I[0])
      idx_byte_ff <= WB_DAT_I[7:0];
  end

  // ********************
  // Address decoder
  // ********************
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      dec_ff <= {CYC_ABS, BYTES_LONG, RGN_RAM, 2'h0, MODE_ABS, 16'h0000};
    else if (wr && WB_ADR_I == OFS_DECODE)
      dec_ff <= decode(WB_DAT_I[15:0], WB_DAT_I[17:16], ctrl_ff);
    else
      dec_ff <= decode(dec_ff.addr, dec_ff.mode, ctrl_ff);
  end

  assign RAM_SEL = dec_ff.region == RGN_RAM;
  assign PERIPH_REG_AREA_SEL = dec_ff.region == RGN_PERIPH_REG_AREA;
  assign ROM_SEL = dec_ff.region == RGN_ROM || dec_ff.region == RGN_VEC;
  assign VEC_SEL = dec_ff.region == RGN_VEC;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  property p_mm_set;
    cmd_exec && op == OP_MEMMODE_ON |=> flags_ff.memmode ##1 status[5] == flags_ff.memmode;
  endproperty
  a_mm_set: assert property (p_mm_set) else $error("memory mode not set");

  property p_mm_dst;
    cmd_exec && op == OP_ADD && flags_ff.memmode && !flags_ff.dec
      |=> idx_byte_ff == 8'($past(idx_byte_ff) + $past(opnd)) && $stable(acc_ff);
  endproperty
  a_mm_dst: assert property (p_mm_dst) else $error("index byte not written");

  property p_acc_dst;
    cmd_exec && op == OP_SUB && !flags_ff.memmode && !flags_ff.dec
      |=> acc_ff == 8'($past(acc_ff) - $past(opnd)) && $stable(idx_byte_ff);
  endproperty
  a_acc_dst: assert property (p_acc_dst) else $error("accumulator not written");

  property p_ovf;
    cmd_exec && op == OP_ADD && !flags_ff.dec && alu_a == 8'h7F && opnd == 8'h01
      |=> flags_ff.ovf && flags_ff.sign;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");

  property p_bit_test;
    cmd_exec && op == OP_BIT_TEST
      |=> flags_ff.ovf == $past(opnd[6]) && flags_ff.sign == $past(opnd[7]);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test copy wrong");

  property p_ovf_rise;
    $rose(flags_ff.ovf) |-> $past(cmd_exec && (op == OP_ADD || op == OP_SUB ||
                                                op == OP_BIT_TEST));
  endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow set directly");

  property p_sign_load;
    cmd_exec && op == OP_LOAD |=> flags_ff.sign == $past(opnd[7]);
  endproperty
  a_sign_load: assert property (p_sign_load) else $error("sign wrong");

  property p_zp;
    wr && WB_ADR_I == OFS_DECODE && WB_DAT_I[17:16] == MODE_ZP
      |=> dec_ff.addr[15:8] == 8'h00 && dec_ff.cycles < CYC_ABS;
  endproperty
  a_zp: assert property (p_zp) else $error("zero page decode wrong");

  property p_periph;
    PERIPH_REG_AREA_SEL |-> dec_ff.addr >= 16'h00C0 && dec_ff.addr <= 16'h00FF && !RAM_SEL;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral area wrong");

  property p_vec;
    VEC_SEL |-> ROM_SEL && dec_ff.addr >= 16'hFFE8;
  endproperty
  a_vec: assert property (p_vec) else $error("vector decode wrong");

  property p_none;
    dec_ff.addr > RAM_HI_END && dec_ff.addr < ROM_BASE_16K
      |-> !(RAM_SEL || PERIPH_REG_AREA_SEL || ROM_SEL || VEC_SEL);
  endproperty
  a_none: assert property (p_none) else $error("stray select");

  c_mm_add: cover property (cmd_exec && op == OP_ADD && flags_ff.memmode);
  c_dec_sub: cover property (cmd_exec && op == OP_SUB && flags_ff.dec);
  c_hi_ram: cover property (RAM_SEL && dec_ff.addr[8]);
  c_vec: cover property (VEC_SEL);

endmodule

// [sim/cfam_mem_stub.sv]
// Far-side stub: turns the decoder selects back into a region code
`timescale 1ns/1ps
module cfam_mem_stub
  import cfam_pkg::*;
(
  input wire logic ram_sel,
  input wire logic periph_reg_area_sel,
  input wire logic rom_sel,
  input wire logic vec_sel,
  output logic [3:0] seen_rgn
);
  // Any mix other than vector inside ROM is a clash
  always_comb
  begin
    case ({ram_sel, periph_reg_area_sel, rom_sel, vec_sel})
      4'h8: seen_rgn = RGN_RAM;
      4'h4: seen_rgn = RGN_PERIPH_REG_AREA;
      4'h2: seen_rgn = RGN_ROM;
      4'h3: seen_rgn = RGN_VEC;
      4'h0: seen_rgn = RGN_NONE;
      default: seen_rgn = 4'hF;
    endcase
  end
endmodule

// [sim/tb.sv]
// Testbench: flag commands and address decoder against a bench model
`timescale 1ns/1ps
module tb
  import cfam_pkg::*;
;
  logic clk, arst_n, cyc, stb, we, ack, ram_s, periph_s, rom_s, vec_s;
  logic [7:0] adr, acc, idx, opnd;
  logic [3:0] sel, seen_rgn, op;
  logic [31:0] dat_w, dat_r, rd;
  logic sg, ov, mm, dc;
  logic [4:0] ctrl;
  logic [1:0] m;
  logic [15:0] a;
  cfam_dec_t e;
  int errors, cmp_count;
  logic [3:0] op_tab [8] = '{OP_ADD, OP_SUB, OP_LOAD, OP_BIT_TEST, OP_MEMMODE_ON,
    OP_MEMMODE_OFF, OP_OVF_CLEAR, OP_NOP};
  logic [15:0] edges [20] = '{16'h0000, 16'h007F, 16'h0080, 16'h00BF, 16'h00C0,
    16'h00FF, 16'h0100, 16'h01BF, 16'h01C0, 16'hBFFF, 16'hC000, 16'hDFFF, 16'hE000,
    16'hEFFF, 16'hF000, 16'hFFE7, 16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFFF};

  cfam_top cfam_top_i (.CLK_SYS(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
    .WB_ACK_O(ack), .RAM_SEL(ram_s), .PERIPH_REG_AREA_SEL(periph_s), .ROM_SEL(rom_s),
    .VEC_SEL(vec_s));
  cfam_mem_stub cfam_mem_stub_i (.ram_sel(ram_s), .periph_reg_area_sel(periph_s),
    .rom_sel(rom_s), .vec_sel(vec_s), .seen_rgn(seen_rgn));

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Entered just after an edge; leaves one idle cycle behind it
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= ad;
    dat_w <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'h1 && n < 20);
    if (n >= 20)
      errors++;
    q = dat_r;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask

  task automatic regs_chk();
    wb(1'h0, OFS_STATUS, '0, rd);
    check("status", rd, {24'h0, sg, ov, mm, 1'h0, dc, 3'h0});
    wb(1'h0, OFS_ACC, '0, rd);
    check("acc", rd, {24'h0, acc});
    wb(1'h0, OFS_INDEX_BYTE, '0, rd);
    check("index", rd, {24'h0, idx});
  endtask

  // ********************
  // Bench model
  // ********************
  task automatic model(input logic [3:0] o_op, input logic [7:0] o);
    logic [7:0] s, r;
    s = mm ? idx : acc;
    r = (o_op == OP_ADD || o_op == OP_SUB) && dc ? bcd(s, o, o_op == OP_SUB) :
      o_op == OP_ADD ? s + o : o_op == OP_SUB ? s - o : o;
    case (o_op)
      OP_MEMMODE_ON: mm = 1'h1;
      OP_MEMMODE_OFF: mm = 1'h0;
      OP_OVF_CLEAR: ov = 1'h0;
      OP_BIT_TEST: {sg, ov} = o[7:6];
      OP_ADD, OP_SUB, OP_LOAD:
      begin
        if (o_op != OP_LOAD)
          ov = (s[7] ^ r[7]) & (s[7] ^ o[7] ^ (o_op == OP_ADD));
        sg = r[7];
        if (mm)
          idx = r;
        else
          acc = r;
      end
      default: ;
    endcase
  endtask

  // Two decimal digits per byte, wrapping at one hundred
  function automatic logic [7:0] bcd(input logic [7:0] s, input logic [7:0] o, input logic sub);
    int x;
    int y;
    x = 10 * int'(s[7:4]) + int'(s[3:0]);
    y = 10 * int'(o[7:4]) + int'(o[3:0]);
    x = sub ? (x + 100 - y) % 100 : (x + y) % 100;
    return {4'(x / 10), 4'(x % 10)};
  endfunction

  // Loads both sources, issues one command and steps the model
  task automatic op_run(input logic [3:0] o_op, input logic [7:0] o);
    wb(1'h1, OFS_ACC, {24'h0, acc}, rd);
    wb(1'h1, OFS_INDEX_BYTE, {24'h0, idx}, rd);
    wb(1'h1, OFS_CMD, {16'h0, o, 4'h0, o_op}, rd);
    model(o_op, o);
  endtask

  function automatic logic [3:0] rgn(input logic [15:0] ea, input logic [4:0] c);
    logic [15:0] rb;
    rb = c[3:2] == 2'h1 ? ROM_BASE_8K : c[3:2] == 2'h2 ? ROM_BASE_16K : ROM_BASE_4K;
    if (ea >= PERIPH_REG_AREA_BASE && ea <= PERIPH_REG_AREA_END)
      return RGN_PERIPH_REG_AREA;
    if (ea <= RAM_END_128 || (c[1:0] != 2'h0 && ea <= RAM_END_192))
      return RGN_RAM;
    if (c[1:0] == 2'h2 && ea >= RAM_HI_BASE && ea <= RAM_HI_END)
      return RGN_RAM;
    if (ea >= (c[4] ? VEC_BASE_LARGE : VEC_BASE_SMALL))
      return RGN_VEC;
    if (ea >= rb)
      return RGN_ROM;
    return RGN_NONE;
  endfunction

  function automatic cfam_dec_t dec_exp(input logic [15:0] da, input logic [1:0] dm,
    input logic [4:0] c);
    cfam_dec_t x;
    x = '0;
    x.mode = dm;
    x.addr = dm == MODE_ZP ? {ZERO_PAGE_HI, da[7:0]} :
      dm == MODE_SP_CALL ? {SPECIAL_PAGE_HI, da[7:0]} : da;
    x.bytes = (dm == MODE_ZP || dm == MODE_SP_CALL) ? BYTES_SHORT : BYTES_LONG;
    x.cycles = dm == MODE_ZP ? CYC_ZP : dm == MODE_ABS ? CYC_ABS :
      dm == MODE_SP_CALL ? CYC_SP_CALL : CYC_ABS_CALL;
    x.region = rgn(x.addr, c);
    return x;
  endfunction

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    {cyc, stb, we, arst_n, sg, ov, mm, dc} = '0;
    {adr, dat_w, acc, idx, ctrl} = '0;
    sel = 4'hF;
    errors = 0;
    cmp_count = 0;
    void'($urandom(91));
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    regs_chk();
    wb(1'h0, OFS_DECODE, '0, rd);
    check("decode_rst", rd, dec_exp('0, MODE_ABS, '0));
    wb(1'h1, OFS_CMD, {28'h0, OP_DEC_ON}, rd);
    dc = 1'h1;
    regs_chk();
    wb(1'h1, OFS_CMD, {28'h0, OP_DEC_OFF}, rd);
    dc = 1'h0;
    repeat (300)
    begin
      op = op_tab[$urandom % 8];
      acc = 8'($urandom);
      idx = 8'($urandom);
      opnd = 8'($urandom);
      op_run(op, opnd);
      regs_chk();
    end
    // Signed range edges in binary mode
    op_run(OP_MEMMODE_OFF, 8'h00);
    acc = 8'h7F;
    op_run(OP_ADD, 8'h01);
    regs_chk();
    acc = 8'h80;
    op_run(OP_SUB, 8'h01);
    regs_chk();
    // Decimal digits; flags carry no meaning here, so only results are checked
    wb(1'h1, OFS_CMD, {28'h0, OP_DEC_ON}, rd);
    dc = 1'h1;
    repeat (40)
    begin
      acc = {4'($urandom % 10), 4'($urandom % 10)};
      idx = {4'($urandom % 10), 4'($urandom % 10)};
      opnd = {4'($urandom % 10), 4'($urandom % 10)};
      op_run($urandom % 2 ? OP_SUB : OP_ADD, opnd);
      wb(1'h0, OFS_ACC, '0, rd);
      check("dec_acc", rd, {24'h0, acc});
      wb(1'h0, OFS_INDEX_BYTE, '0, rd);
      check("dec_index", rd, {24'h0, idx});
    end
    wb(1'h1, OFS_CMD, {28'h0, OP_DEC_OFF}, rd);
    dc = 1'h0;
    op_run(OP_OVF_CLEAR, 8'h00);
    op_run(OP_LOAD, opnd);
    regs_chk();
    // Flags must not be writable through the status place
    wb(1'h1, OFS_STATUS, 32'hFFFF_FFFF, rd);
    regs_chk();
    wb(1'h1, 8'h18, 32'hFFFF_FFFF, rd);
    wb(1'h0, 8'h18, '0, rd);
    check("unmapped", rd, '0);
    for (int c = 0; c < 32; c++)
    begin
      ctrl = 5'(c);
      wb(1'h1, OFS_CTRL, {27'h0, ctrl}, rd);
      wb(1'h0, OFS_CTRL, '0, rd);
      check("ctrl", rd, {27'h0, ctrl});
      for (int i = 0; i < 22; i++)
      begin
        m = 2'($urandom);
        a = i < 20 ? edges[i] : 16'($urandom);
        wb(1'h1, OFS_DECODE, {14'h0, m, a}, rd);
        wb(1'h0, OFS_DECODE, '0, rd);
        e = dec_exp(a, m, ctrl);
        check("decode", rd, e);
        check("sel_pins", {28'h0, seen_rgn}, {28'h0, e.region});
      end
    end
    // Second reset in mid-run must bring every register back
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    {sg, ov, mm, dc, acc, idx} = '0;
    @(posedge clk);
    regs_chk();
    wb(1'h0, OFS_CTRL, '0, rd);
    check("ctrl_rst", rd, '0);
    wb(1'h0, OFS_DECODE, '0, rd);
    check("decode_rst2", rd, dec_exp('0, MODE_ABS, '0));
    report_and_stop();
  end

  // Roughly five times the expected run length
  initial
  begin
    #1_000_000;
    errors++;
    report_and_stop();
  end
endmodule
